// ### src/bitblt_engine_setup.v
// block-transfer engine: apb register file, sequencer and byte datapath
`timescale 1ns/1ps
`default_nettype none
`include "bitblt_engine_setup_consts.vh"

module bitblt_engine_setup #(
  parameter AW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  output reg           fb_req,
  output reg           fb_we,
  output reg  [22:0]   fb_addr,
  output reg  [7:0]    fb_wdata,
  input  wire          fb_ack,
  input  wire [7:0]    fb_rdata,
  output reg           busy
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_PAT  = 3'd1;
  localparam [2:0] S_SRC  = 3'd2;
  localparam [2:0] S_DST  = 3'd3;
  localparam [2:0] S_WR   = 3'd4;
  localparam [2:0] S_NEXT = 3'd5;

  // ==========================================================
  // functions
  function [7:0] lane;
    input [23:0] c;
    input [1:0]  i;
    begin
      lane = (i == 2'd0) ? c[7:0] : (i == 2'd1) ? c[15:8] : c[23:16];
    end
  endfunction

  function [7:0] rop3;
    input [7:0] r;
    input [7:0] p;
    input [7:0] s;
    input [7:0] d;
    integer k;
    begin
      rop3 = 8'h00;
      for (k = 0; k < 8; k = k + 1)
        rop3[k] = r[{p[k], s[k], d[k]}];
    end
  endfunction

  // ==========================================================
  // registers
  reg [31:0] ofs_q;
  reg [31:0] ctl_q;
  reg [31:0] msc_q;
  reg [31:0] pat_q;
  reg [31:0] src_q;
  reg [31:0] dst_q;
  reg [31:0] ext_q;
  reg [23:0] bg_q;
  reg [23:0] fg_q;
  reg [23:0] sbg_q;
  reg [23:0] sfg_q;
  reg [7:0]  cfg_q;

  reg [2:0]  st_q;
  reg [12:0] xb_q;
  reg [12:0] y_q;
  reg [1:0]  bi_q;
  reg [2:0]  pxc_q;
  reg [2:0]  prow_q;
  reg [3:0]  left_q;
  reg [7:0]  pbyte_q;
  reg [7:0]  sbyte_q;
  reg [7:0]  dbyte_q;
  reg [22:0] dline_q;
  reg [22:0] sline_q;
  reg [22:0] saddr_q;
  reg [31:0] hbuf_q;
  reg [2:0]  hcnt_q;

  // ==========================================================
  // apb decode
  wire acc     = psel & penable;
  wire is_dp   = (paddr == `OFS_DATAPORT);
  wire hold    = is_dp & pwrite & busy & (hcnt_q != 3'd0);
  wire mapped  = (paddr <= `OFS_DATAPORT) & (paddr[1:0] == 2'b00);
  wire wr_fire = acc & pready & pwrite & ~pslverr;
  wire wr_ext  = wr_fire & (paddr == `OFS_EXTENT);
  wire dp_wr   = wr_fire & is_dp;
  wire start   = wr_ext & (pwdata[28:16] != 13'd0) & ~busy
                 & ~cfg_q[`CFG_HALT];

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_OFFSETS:  rd_mux = ofs_q;
      `OFS_CONTROL:  rd_mux = {busy, ctl_q[30:0]};
      `OFS_MONOCTL:  rd_mux = msc_q;
      `OFS_PATBASE:  rd_mux = pat_q;
      `OFS_SRCBASE:  rd_mux = src_q;
      `OFS_DSTBASE:  rd_mux = dst_q;
      `OFS_EXTENT:   rd_mux = ext_q;
      `OFS_SHBG:     rd_mux = {8'h00, bg_q};
      `OFS_SHFG:     rd_mux = {8'h00, fg_q};
      `OFS_SRCBG:    rd_mux = {8'h00, sbg_q};
      `OFS_SRCFG:    rd_mux = {8'h00, sfg_q};
      `OFS_CONFIG:   rd_mux = {24'h000000, cfg_q[7:1], busy};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc & ~pready & ~hold;
      pslverr <= acc & ~pready & ~hold & ~mapped;
      prdata  <= (acc & ~pready & ~pwrite & mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ofs_q <= `RST_ZERO32;
      ctl_q <= `RST_ZERO32;
      msc_q <= `RST_ZERO32;
      pat_q <= `RST_ZERO32;
      src_q <= `RST_ZERO32;
      dst_q <= `RST_ZERO32;
      ext_q <= `RST_ZERO32;
      bg_q  <= 24'h000000;
      fg_q  <= 24'h000000;
      sbg_q <= 24'h000000;
      sfg_q <= 24'h000000;
      cfg_q <= `RST_CONFIG;
    end
    else if (wr_fire)
    begin
      case (paddr)
        `OFS_OFFSETS: ofs_q <= {3'b000, pwdata[28:16], 3'b000, pwdata[12:0]};
        `OFS_CONTROL: ctl_q <= {1'b0, pwdata[30:0]};
        `OFS_MONOCTL: msc_q <= pwdata;
        `OFS_PATBASE: pat_q <= {9'h000, pwdata[22:3], 3'b000};
        `OFS_SRCBASE: src_q <= {9'h000, pwdata[22:0]};
        `OFS_DSTBASE: dst_q <= {9'h000, pwdata[22:0]};
        `OFS_EXTENT:  ext_q <= {3'b000, pwdata[28:16], 3'b000, pwdata[12:0]};
        `OFS_SHBG:    bg_q  <= pwdata[23:0];
        `OFS_SHFG:    fg_q  <= pwdata[23:0];
        `OFS_SRCBG:   sbg_q <= pwdata[23:0];
        `OFS_SRCFG:   sfg_q <= pwdata[23:0];
        `OFS_CONFIG:  cfg_q <= {pwdata[7:1], 1'b0};
        default:      cfg_q <= cfg_q;
      endcase
    end
  end

  // ==========================================================
  // operation decode
  wire [1:0] depth = ctl_q[`CTL_DEPTH_EN] ? ctl_q[`CTL_DEPTH_HI:`CTL_DEPTH_LO]
                   : cfg_q[`CFG_DEPTH_HI:`CFG_DEPTH_LO];
  wire [1:0] bpp   = (depth == `DEPTH_16) ? 2'd2 :
                     (depth == `DEPTH_24) ? 2'd3 : 2'd1;
  wire [7:0] rop   = ctl_q[7:0];
  wire uses_pat    = (rop[7:4] != rop[3:0]);
  wire uses_src    = ({rop[7:6], rop[3:2]} != {rop[5:4], rop[1:0]});
  wire uses_dst    = ({rop[7], rop[5], rop[3], rop[1]} != {rop[6], rop[4], rop[2], rop[0]});
  wire fetch_pat   = uses_pat & ~ctl_q[`CTL_PAT_SOLID];
  wire mono        = ctl_q[`CTL_SRC_MONO];
  wire mask_mono   = ctl_q[`CTL_MASK_SRC] & mono
                   & ~|ctl_q[`CTL_MASK_HI:`CTL_MASK_LO];
  wire src_on      = uses_src | mask_mono;
  wire need_s      = src_on & (mono ? ((bi_q == 2'd0) & (left_q == 4'd0)) : 1'b1);
  wire alt_cols    = mono & msc_q[`MSC_SRC_COLS];
  wire [23:0] s_fg = alt_cols ? sfg_q : fg_q;
  wire [23:0] s_bg = alt_cols ? sbg_q : bg_q;
  wire [2:0] sidx  = left_q[2:0] - 3'd1;
  wire sbit        = sbyte_q[sidx];
  wire pbit        = pbyte_q[3'd7 - pxc_q];
  wire [7:0] src_b = mono ? lane(sbit ? s_fg : s_bg, bi_q) : sbyte_q;
  wire [7:0] pat_b = ctl_q[`CTL_PAT_SOLID] ? lane(fg_q, bi_q) :
                     ctl_q[`CTL_PAT_MONO] ? lane(pbit ? fg_q : bg_q, bi_q) :
                     pbyte_q;
  wire [7:0] res_b = rop3(rop, pat_b, src_b, dbyte_q);
  wire masked      = mask_mono & ~sbit;
  wire [4:0] pxo   = pxc_q * bpp;

  reg [22:0] pofs;
  always @*
  begin
    pofs = 23'h000000;
    if (ctl_q[`CTL_PAT_MONO])
      pofs = {20'h00000, prow_q};
    else
    begin
      case (bpp)
        2'd2:    pofs = {16'h0000, prow_q, 4'h0};
        2'd3:    pofs = {15'h0000, prow_q, 5'h00};
        default: pofs = {17'h00000, prow_q, 3'h0};
      endcase
      pofs = pofs + {18'h00000, pxo} + {21'h000000, bi_q};
    end
  end

  wire [22:0] pat_addr = pat_q[22:0] + pofs;
  wire [22:0] dst_addr = dline_q + {10'h000, xb_q};
  wire px_end  = (bi_q == bpp - 2'd1);
  wire ln_end  = (xb_q == ext_q[12:0] - 13'd1);
  wire op_end  = (y_q == ext_q[28:16] - 13'd1);
  wire [22:0] dline_n = dline_q + {10'h000, ofs_q[28:16]};
  wire [22:0] sline_n = sline_q + {10'h000, ofs_q[12:0]};

  // ==========================================================
  // sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= S_IDLE;
      busy <= 1'b0;
      fb_req <= 1'b0;
      fb_we <= 1'b0;
      fb_addr <= 23'h000000;
      fb_wdata <= 8'h00;
      xb_q <= 13'h0000;
      y_q <= 13'h0000;
      bi_q <= 2'd0;
      pxc_q <= 3'd0;
      prow_q <= 3'd0;
      left_q <= 4'd0;
      pbyte_q <= 8'h00;
      sbyte_q <= 8'h00;
      dbyte_q <= 8'h00;
      dline_q <= 23'h000000;
      sline_q <= 23'h000000;
      saddr_q <= 23'h000000;
      hbuf_q <= 32'h0000_0000;
      hcnt_q <= 3'd0;
    end
    else if (cfg_q[`CFG_HALT])
    begin
      st_q <= S_IDLE;
      busy <= 1'b0;
      fb_req <= 1'b0;
      hcnt_q <= 3'd0;
    end
    else
    begin
      if (dp_wr)
      begin
        hbuf_q <= pwdata;
        hcnt_q <= `HOST_BYTES;
      end
      case (st_q)
        S_IDLE:
        begin
          if (start)
          begin
            busy <= 1'b1;
            st_q <= (pwdata[12:0] == 13'd0) ? S_IDLE : S_PAT;
            busy <= (pwdata[12:0] != 13'd0);
            xb_q <= 13'h0000;
            y_q <= 13'h0000;
            bi_q <= 2'd0;
            pxc_q <= 3'd0;
            prow_q <= ctl_q[`CTL_ROW_HI:`CTL_ROW_LO];
            left_q <= 4'd0;
            hcnt_q <= 3'd0;
            dline_q <= dst_q[22:0];
            sline_q <= src_q[22:0];
            saddr_q <= src_q[22:0];
          end
        end
        S_PAT:
        begin
          if (!fetch_pat)
            st_q <= S_SRC;
          else if (!fb_req)
          begin
            fb_req <= 1'b1;
            fb_we <= 1'b0;
            fb_addr <= pat_addr;
          end
          else if (fb_ack)
          begin
            fb_req <= 1'b0;
            pbyte_q <= fb_rdata;
            st_q <= S_SRC;
          end
        end
        S_SRC:
        begin
          if (!need_s)
            st_q <= S_DST;
          else if (ctl_q[`CTL_SRC_HOST])
          begin
            if (hcnt_q != 3'd0)
            begin
              sbyte_q <= hbuf_q[7:0];
              hbuf_q <= {8'h00, hbuf_q[31:8]};
              hcnt_q <= hcnt_q - 3'd1;
              left_q <= 4'd8;
              st_q <= S_DST;
            end
          end
          else if (!fb_req)
          begin
            fb_req <= 1'b1;
            fb_we <= 1'b0;
            fb_addr <= saddr_q;
          end
          else if (fb_ack)
          begin
            fb_req <= 1'b0;
            sbyte_q <= fb_rdata;
            saddr_q <= saddr_q + 23'd1;
            left_q <= 4'd8;
            st_q <= S_DST;
          end
        end
        S_DST:
        begin
          if (!uses_dst)
            st_q <= S_WR;
          else if (!fb_req)
          begin
            fb_req <= 1'b1;
            fb_we <= 1'b0;
            fb_addr <= dst_addr;
          end
          else if (fb_ack)
          begin
            fb_req <= 1'b0;
            dbyte_q <= fb_rdata;
            st_q <= S_WR;
          end
        end
        S_WR:
        begin
          if (masked)
            st_q <= S_NEXT;
          else if (!fb_req)
          begin
            fb_req <= 1'b1;
            fb_we <= 1'b1;
            fb_addr <= dst_addr;
            fb_wdata <= res_b;
          end
          else if (fb_ack)
          begin
            fb_req <= 1'b0;
            fb_we <= 1'b0;
            st_q <= S_NEXT;
          end
        end
        S_NEXT:
        begin
          if (px_end)
          begin
            bi_q <= 2'd0;
            pxc_q <= pxc_q + 3'd1;
            if (mono && left_q != 4'd0)
              left_q <= left_q - 4'd1;
          end
          else
            bi_q <= bi_q + 2'd1;
          if (!ln_end)
          begin
            xb_q <= xb_q + 13'd1;
            st_q <= S_PAT;
          end
          else if (op_end)
          begin
            busy <= 1'b0;
            st_q <= S_IDLE;
          end
          else
          begin
            xb_q <= 13'h0000;
            y_q <= y_q + 13'd1;
            bi_q <= 2'd0;
            pxc_q <= 3'd0;
            left_q <= 4'd0;
            prow_q <= prow_q + 3'd1;
            dline_q <= dline_n;
            sline_q <= sline_n;
            saddr_q <= sline_n;
            st_q <= S_PAT;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

endmodule // bitblt_engine_setup

`default_nettype wire

// ### src/bitblt_engine_setup_consts.vh
// constants for the block-transfer engine register file and fields
// ==========================================================
// Overview of operation
// - busy shows in configuration bit 0 and control bit 31; reprogram only idle
// - configuration zero means 8 bits per pixel and normal running
// - control bit 23 set takes depth from control bits 25-24
// - configuration bit 1 must be zero to run operations
// - control bits 22-20 pick the pattern row for the first line
// - control bit 19 clear uses pattern bytes fetched from memory
// - control bits 18-17 zero mean colour pattern at current depth
// - control bits 16-13 zero write every destination pixel
// - control bit 12 clear ignores the mono source control register
// - source handling bits 10-8 matter only when source is used
// - control bits 7-0 hold the raster code; f0 copies pattern
// - no source operand and no mono source mask means no source fetch and no host wait
// - offsets hold destination pitch 28-16, source pitch 12-0
// - pattern base bits 22-3 give a quadword aligned offset
// - destination base bits 22-0 give the first written byte
// - extent holds height 28-16 in lines, width 12-0 in bytes
// - writing a non-zero height with a non-zero width starts the operation
// - the 8x8 pattern tiles across the whole rectangle
// - host writes to the data port supply source bytes
// - mono source is colour expanded to the current depth
// - mono source as mask leaves pixels at zero bits unchanged
// - expansion turns one into foreground and zero into background
// - control bit 12 set marks the source as monochrome
// - control bit 10 set takes source from the host
`ifndef BITBLT_ENGINE_SETUP_CONSTS_VH
`define BITBLT_ENGINE_SETUP_CONSTS_VH
// ==========================================================
// register byte offsets
`define OFS_OFFSETS  8'h00
`define OFS_CONTROL  8'h04
`define OFS_MONOCTL  8'h08
`define OFS_PATBASE  8'h0c
`define OFS_SRCBASE  8'h10
`define OFS_DSTBASE  8'h14
`define OFS_EXTENT   8'h18
`define OFS_SHBG     8'h1c
`define OFS_SHFG     8'h20
`define OFS_SRCBG    8'h24
`define OFS_SRCFG    8'h28
`define OFS_CONFIG   8'h2c
`define OFS_DATAPORT 8'h30
// ==========================================================
// field positions
`define CTL_BUSY     31
`define CTL_DEPTH_HI 25
`define CTL_DEPTH_LO 24
`define CTL_DEPTH_EN 23
`define CTL_ROW_HI   22
`define CTL_ROW_LO   20
`define CTL_PAT_SOLID 19
`define CTL_PAT_MONO 18
`define CTL_MASK_HI  16
`define CTL_MASK_LO  14
`define CTL_MASK_SRC 13
`define CTL_SRC_MONO 12
`define CTL_SRC_HOST 10
`define MSC_SRC_COLS 27
`define CFG_BUSY     0
`define CFG_HALT     1
`define CFG_DEPTH_HI 5
`define CFG_DEPTH_LO 4
// ==========================================================
// reset values and depth codes
`define RST_ZERO32   32'h0000_0000
`define RST_CONFIG   8'h00
`define DEPTH_16     2'h1
`define DEPTH_24     2'h2
`define HOST_BYTES   3'h4
`endif

// ### testbench/bitblt_engine_setup_props.sv
// concurrent checks on the block-transfer engine ports
`timescale 1ns/1ps
`default_nettype none
module bitblt_engine_setup_props #(
  parameter AW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          fb_req,
  input wire logic          fb_we,
  input wire logic [22:0]   fb_addr,
  input wire logic [7:0]    fb_wdata,
  input wire logic          fb_ack,
  input wire logic [7:0]    fb_rdata,
  input wire logic          busy
);
  // ==========================================================
  // helper: halt bit as last written
  logic halt_q;
  wire  done_w = psel && penable && pready;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halt_q <= 1'b0;
    else if (done_w && pwrite && paddr == 8'h2c)
      halt_q <= pwdata[1];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // sequences
  sequence s_ext_wr;
    done_w && pwrite && paddr == 8'h18 && !busy && !halt_q;
  endsequence
  sequence s_go;
    s_ext_wr ##0 (pwdata[28:16] != 13'h0 && pwdata[12:0] != 13'h0);
  endsequence
  // ==========================================================
  // properties
  AST_START_BUSY: assert property (s_go |=> busy)
    else $error("busy did not rise on start");
  AST_ZERO_HEIGHT: assert property (s_ext_wr ##0 pwdata[28:16] == 13'h0 |=> !busy)
    else $error("zero height started an operation");
  AST_CFG_BUSY: assert property (pready && !pwrite && paddr == 8'h2c && $stable(busy)
    |-> prdata[0] == busy)
    else $error("config bit0 differs from busy");
  AST_CTL_BUSY: assert property (pready && !pwrite && paddr == 8'h04 && $stable(busy)
    |-> prdata[31] == busy)
    else $error("control bit31 differs from busy");
  AST_IDLE_NO_FB: assert property (!busy |-> !fb_req)
    else $error("frame buffer access while idle");
  AST_FB_HOLD: assert property (fb_req && !fb_ack
    |=> fb_req && $stable(fb_addr) && $stable(fb_we) && $stable(fb_wdata))
    else $error("frame buffer request changed before ack");
  AST_FB_DROP: assert property (fb_req && fb_ack |=> !fb_req)
    else $error("frame buffer request held after ack");
  AST_READY_PULSE: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or longer than one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // bitblt_engine_setup_props
bind bitblt_engine_setup bitblt_engine_setup_props #(.AW(AW)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fb_req(fb_req), .fb_we(fb_we), .fb_addr(fb_addr), .fb_wdata(fb_wdata),
  .fb_ack(fb_ack), .fb_rdata(fb_rdata), .busy(busy));
`default_nettype wire

// ### testbench/bitblt_engine_setup_tb.sv
// self-checking testbench for the block-transfer engine
`timescale 1ns/1ps
`default_nettype none
module bitblt_engine_setup_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  lat = 3'h1;
  logic [31:0] prdata;
  logic        pready, pslverr, fb_req, fb_we, fb_ack, busy, err;
  logic [22:0] fb_addr;
  logic [7:0]  fb_wdata, fb_rdata, b;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #2.5 pclk = ~pclk;
  bitblt_engine_setup #(.AW(8)) bitblt_engine_setup_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fb_req(fb_req), .fb_we(fb_we), .fb_addr(fb_addr), .fb_wdata(fb_wdata),
    .fb_ack(fb_ack), .fb_rdata(fb_rdata), .busy(busy));
  fb_mem_model fb_mem_model_i (
    .pclk(pclk), .presetn(presetn), .fb_req(fb_req), .fb_we(fb_we), .fb_addr(fb_addr),
    .fb_wdata(fb_wdata), .lat(lat), .fb_ack(fb_ack), .fb_rdata(fb_rdata));
  // ==========================================================
  // common tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 200);
    if (n >= 200)
      n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h2c, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 1000);
    if (n >= 1000)
      n_mismatch++;
  endtask
  task check_mem(input int a, input logic [7:0] e);
    check({24'h0, fb_mem_model_i.mem[a]}, {24'h0, e});
  endtask
  // ==========================================================
  // scenarios
  task t_reset_values();
    apb(1'b0, 8'h2c, 32'h0); check(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0); check(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0); check(rd, 32'h0);
  endtask
  task t_refusal();
    apb(1'b0, 8'h34, 32'h0); check({31'h0, err}, 32'h1); check(rd, 32'h0);
    apb(1'b1, 8'h05, 32'h1); check({31'h0, err}, 32'h1);
  endtask
  task t_field_widths();
    apb(1'b1, 8'h14, 32'hffffffff); apb(1'b0, 8'h14, 32'h0); check(rd, 32'h007fffff);
    apb(1'b1, 8'h0c, 32'hffffffff); apb(1'b0, 8'h0c, 32'h0); check(rd, 32'h007ffff8);
    apb(1'b1, 8'h00, 32'hffffffff); apb(1'b0, 8'h00, 32'h0); check(rd, 32'h1fff1fff);
  endtask
  task t_zero_height();
    apb(1'b1, 8'h18, 32'h00000040);
    apb(1'b0, 8'h2c, 32'h0); check(rd, 32'h0);
  endtask
  task t_pattern_fill();
    lat <= 3'h4;
    for (int i = 0; i < 64; i++) fb_mem_model_i.mem[12'h100 + i] = 8'h40 + 8'(i);
    apb(1'b1, 8'h00, 32'h00100000);
    apb(1'b1, 8'h0c, 32'h00000100);
    apb(1'b1, 8'h14, 32'h00000800);
    apb(1'b1, 8'h04, 32'h003000f0);
    apb(1'b1, 8'h18, 32'h00090009);
    apb(1'b0, 8'h04, 32'h0); check(rd, 32'h803000f0);
    wait_idle();
    apb(1'b0, 8'h04, 32'h0); check(rd, 32'h003000f0);
    for (int y = 0; y < 9; y++)
      for (int x = 0; x < 9; x++)
        check_mem(12'h800 + y * 16 + x, 8'h40 + 8'(((y + 3) % 8) * 8 + x % 8));
  endtask
  task t_host_mask();
    lat <= 3'h0;
    for (int i = 0; i < 32; i++) fb_mem_model_i.mem[12'ha00 + i] = 8'h55;
    apb(1'b1, 8'h14, 32'h00000a00);
    apb(1'b1, 8'h20, 32'h000000e7);
    apb(1'b1, 8'h04, 32'h000034cc);
    apb(1'b1, 8'h18, 32'h00020008);
    apb(1'b1, 8'h30, 32'h00003ca5);
    wait_idle();
    for (int y = 0; y < 2; y++)
    begin
      b = (y == 0) ? 8'ha5 : 8'h3c;
      for (int x = 0; x < 8; x++)
        check_mem(12'ha00 + y * 16 + x, b[7 - x] ? 8'he7 : 8'h55);
    end
  endtask
  task t_mono_expand();
    apb(1'b1, 8'h14, 32'h00000c00);
    apb(1'b1, 8'h1c, 32'h00005678);
    apb(1'b1, 8'h20, 32'h00001234);
    apb(1'b1, 8'h04, 32'h018014cc);
    apb(1'b1, 8'h18, 32'h00010004);
    apb(1'b1, 8'h30, 32'h00000080);
    wait_idle();
    check_mem(12'hc00, 8'h34);
    check_mem(12'hc01, 8'h12);
    check_mem(12'hc02, 8'h78);
    check_mem(12'hc03, 8'h56);
  endtask
  task t_halt();
    apb(1'b1, 8'h2c, 32'h00000002);
    apb(1'b1, 8'h18, 32'h00010001);
    apb(1'b0, 8'h2c, 32'h0); check(rd, 32'h00000002);
    apb(1'b0, 8'h04, 32'h0); check(rd, 32'h018014cc);
    apb(1'b1, 8'h2c, 32'h0);
  endtask
  // ==========================================================
  // verdict and run control
  task end_of_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_refusal();
    t_field_widths();
    t_zero_height();
    t_pattern_fill();
    t_host_mask();
    t_mono_expand();
    t_halt();
    end_of_test();
  end
endmodule // bitblt_engine_setup_tb
`default_nettype wire

// ### testbench/fb_mem_model.sv
// frame buffer memory model answering engine requests
`timescale 1ns/1ps
`default_nettype none
module fb_mem_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        fb_req,
  input wire logic        fb_we,
  input wire logic [22:0] fb_addr,
  input wire logic [7:0]  fb_wdata,
  input wire logic [2:0]  lat,
  output var logic        fb_ack,
  output var logic [7:0]  fb_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] rd_q;
  logic [2:0] wait_q;
  // ==========================================================
  // read data only valid with ack, garbage otherwise
  assign fb_rdata = fb_ack ? rd_q : ~rd_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fb_ack <= 1'b0;
      wait_q <= 3'h0;
      rd_q   <= 8'h00;
    end
    else
    begin
      fb_ack <= 1'b0;
      if (fb_req && !fb_ack)
      begin
        if (wait_q >= lat)
        begin
          fb_ack <= 1'b1;
          wait_q <= 3'h0;
          if (fb_we)
            mem[fb_addr[11:0]] <= fb_wdata;
          else
            rd_q <= mem[fb_addr[11:0]];
        end
        else
          wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule // fb_mem_model
`default_nettype wire
